// ==== rtl/ccu_cfg.svh ====
// Constants of the capture/compare unit pair and timebase B: offsets, fields, codes
//
// Behaviour
// - Timebase B wraps FFFFh to 0000h, sets overflow
// - Overflow request forwarded only while enable bit set
// - Trigger in mode 1011 clears the unit's selected timebase, A or B
// - Trigger clear never sets the overflow flag
// - Software timebase write beats a simultaneous trigger clear
// - Mode 0000 disables and resets; 0001/0011 reserved
// - Capture edge chosen by mode 0100 to 0111
// - Mode 0010 match toggles pin, sets event flag
// - Mode 1000 pin starts low, match forces high
// - Mode 1001 pin starts high, match forces low
// - Mode 1010 match sets flag, pin untouched
// - Mode 1011 match sets flag, pulses trigger
// - Modes 11xx PWM; bits 5-4 duty low bits
// - Value register is two separately accessible bytes
// - Capture/compare use timebase A or B per unit
// - Both PWM units update together on timebase C
// - Capture copies full selected timebase count
// - Event flag set by hardware, cleared only by software
// - New capture overwrites unread value, no overrun
// - Pin level changes from port writes still capture
// - Units identical except special trigger targets and timebase B select (unit two also takes B on bit 3)
// - Compare checks value against timebase every cycle
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH

// Register byte offsets
`define CCU_OFF_TBB_LO 8'h00
`define CCU_OFF_TBB_HI 8'h04
`define CCU_OFF_TBB_CTRL 8'h08
`define CCU_OFF_TBA_CTRL 8'h0c
`define CCU_OFF_FLAGS2 8'h10
`define CCU_OFF_ENABLES2 8'h14
`define CCU_OFF_PRIO2 8'h18
`define CCU_OFF_U1_CTRL 8'h1c
`define CCU_OFF_U1_LO 8'h20
`define CCU_OFF_U1_HI 8'h24
`define CCU_OFF_U2_CTRL 8'h28
`define CCU_OFF_U2_LO 8'h2c
`define CCU_OFF_U2_HI 8'h30
`define CCU_OFF_FLAGS1 8'h34
`define CCU_OFF_TBA_CNT 8'h38
`define CCU_OFF_GIC 8'h3c

// Timebase B control fields
`define CCU_TB_RUN 0
`define CCU_TBB_EXT 1
`define CCU_TBB_SEL1 3
`define CCU_TBB_PS_LO 4
`define CCU_TBB_PS_HI 5
`define CCU_TBB_SEL2 6

// Flag and enable bit positions
`define CCU_F2_UNIT2 0
`define CCU_F2_OVF 1
`define CCU_F1_UNIT1 2

// Unit control fields
`define CCU_UC_MODE_HI 3
`define CCU_UC_DC_LO 4
`define CCU_UC_DC_HI 5

// Mode codes
`define CCU_M_OFF 4'h0
`define CCU_M_TOGGLE 4'h2
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_4 4'h6
`define CCU_M_CAP_16 4'h7
`define CCU_M_CMP_HIGH 4'h8
`define CCU_M_CMP_LOW 4'h9
`define CCU_M_CMP_SOFT 4'ha
`define CCU_M_CMP_TRIG 4'hb
`define CCU_PWM_PFX 2'h3

// Counts and reset values
`define CCU_CAP4_LAST 4'h3
`define CCU_CAP16_LAST 4'hf
`define CCU_TB_MAX 16'hffff
`define CCU_TB_ZERO 16'h0000
`define CCU_CTRL_RST 8'h00
`define CCU_PRIO2_RST 5'h1f

`endif

// ==== rtl/ccu_pkg.sv ====
// Types shared by the capture/compare unit pair
package ccu_pkg;
  typedef logic [3:0] ccu_mode_t;
  typedef logic [15:0] ccu_count_t;
  typedef enum logic [2:0] {
    CCU_CLS_OFF,
    CCU_CLS_CAPTURE,
    CCU_CLS_COMPARE,
    CCU_CLS_PWM,
    CCU_CLS_RSVD
  } ccu_cls_e;
endpackage

// ==== rtl/ccu_top.sv ====
// Two capture/compare units, timebase A and timebase B behind an APB slave
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "ccu_cfg.svh"

module ccu_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire ccu_pkg::ccu_mode_t mode,
  input wire ccu_pkg::ccu_count_t tb_count,
  input wire logic pin_in,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  output ccu_pkg::ccu_count_t value,
  output logic pin_out,
  output logic pin_oe_n,
  output logic event_pulse,
  output logic trig_pulse
);
  import ccu_pkg::*;

  ccu_cls_e cls;
  logic match;
  logic match_rise;
  logic entered;
  logic rise;
  logic fall;
  logic cap_evt;
  ccu_count_t value_ff, nxt_value;
  logic pin_q_ff, nxt_pin_q;
  logic latch_ff, nxt_latch;
  logic oe_n_ff, nxt_oe_n;
  ccu_mode_t mode_q_ff, nxt_mode_q;
  logic match_q_ff, nxt_match_q;
  logic [3:0] ps_ff, nxt_ps;
  logic evt_ff, nxt_evt;
  logic trig_ff, nxt_trig;

  assign value = value_ff;
  assign pin_out = latch_ff;
  assign pin_oe_n = oe_n_ff;
  assign event_pulse = evt_ff;
  assign trig_pulse = trig_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    if (mode[`CCU_UC_MODE_HI -: 2] == `CCU_PWM_PFX) begin
      cls = CCU_CLS_PWM;
    end else begin
      case (mode)
        `CCU_M_OFF: cls = CCU_CLS_OFF;
        `CCU_M_CAP_FALL, `CCU_M_CAP_RISE, `CCU_M_CAP_4, `CCU_M_CAP_16: cls = CCU_CLS_CAPTURE;
        `CCU_M_TOGGLE, `CCU_M_CMP_HIGH, `CCU_M_CMP_LOW, `CCU_M_CMP_SOFT,
        `CCU_M_CMP_TRIG: cls = CCU_CLS_COMPARE;
        default: cls = CCU_CLS_RSVD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection
  always_comb begin
    // Edge-based match so a long equality does not toggle every cycle
    match = (cls == CCU_CLS_COMPARE) && (tb_count == value_ff);
    match_rise = match && !match_q_ff;
    entered = (mode != mode_q_ff);
    // Pin level includes the unit's own drive, so port writes can capture
    rise = !pin_q_ff && pin_in;
    fall = pin_q_ff && !pin_in;
    case (mode)
      `CCU_M_CAP_FALL: cap_evt = fall;
      `CCU_M_CAP_RISE: cap_evt = rise;
      `CCU_M_CAP_4: cap_evt = rise && (ps_ff == `CCU_CAP4_LAST);
      `CCU_M_CAP_16: cap_evt = rise && (ps_ff == `CCU_CAP16_LAST);
      default: cap_evt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_value = value_ff;
    if (wr_lo) begin
      nxt_value[7:0] = wdata;
    end
    if (wr_hi) begin
      nxt_value[15:8] = wdata;
    end
    if (cap_evt) begin
      nxt_value = tb_count;
    end
    nxt_ps = ps_ff;
    if ((cls != CCU_CLS_CAPTURE) || cap_evt) begin
      nxt_ps = 4'h0;
    end else if (rise && ((mode == `CCU_M_CAP_4) || (mode == `CCU_M_CAP_16))) begin
      nxt_ps = ps_ff + 4'h1;
    end
    nxt_latch = latch_ff;
    if (cls == CCU_CLS_OFF) begin
      nxt_latch = 1'b0;
    end else if (entered && (mode == `CCU_M_CMP_HIGH)) begin
      nxt_latch = 1'b0;
    end else if (entered && (mode == `CCU_M_CMP_LOW)) begin
      nxt_latch = 1'b1;
    end else if (match_rise) begin
      case (mode)
        `CCU_M_TOGGLE: nxt_latch = !latch_ff;
        `CCU_M_CMP_HIGH: nxt_latch = 1'b1;
        `CCU_M_CMP_LOW: nxt_latch = 1'b0;
        default: nxt_latch = latch_ff;
      endcase
    end
    nxt_oe_n = !((mode == `CCU_M_TOGGLE) || (mode == `CCU_M_CMP_HIGH) ||
                 (mode == `CCU_M_CMP_LOW));
    nxt_evt = cap_evt || match_rise;
    nxt_trig = match_rise && (mode == `CCU_M_CMP_TRIG);
    nxt_pin_q = pin_in;
    nxt_mode_q = mode;
    nxt_match_q = match;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= `CCU_TB_ZERO;
      pin_q_ff <= 1'b0;
      latch_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      mode_q_ff <= `CCU_M_OFF;
      match_q_ff <= 1'b0;
      ps_ff <= 4'h0;
      evt_ff <= 1'b0;
      trig_ff <= 1'b0;
    end else begin
      value_ff <= nxt_value;
      pin_q_ff <= nxt_pin_q;
      latch_ff <= nxt_latch;
      oe_n_ff <= nxt_oe_n;
      mode_q_ff <= nxt_mode_q;
      match_q_ff <= nxt_match_q;
      ps_ff <= nxt_ps;
      evt_ff <= nxt_evt;
      trig_ff <= nxt_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_match(ccu_mode_t m);
    match_rise && !entered && (mode == m);
  endsequence

  property p_toggle;
    s_match(`CCU_M_TOGGLE) |=> (pin_out != $past(pin_out)) && event_pulse;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_high;
    s_match(`CCU_M_CMP_HIGH) |=> pin_out && event_pulse;
  endproperty
  a_high: assert property (p_high) else $error("force high missed");

  property p_init_low;
    (entered && mode == `CCU_M_CMP_HIGH) |=> !pin_out;
  endproperty
  a_init_low: assert property (p_init_low) else $error("init low missed");

  property p_force_low;
    s_match(`CCU_M_CMP_LOW) |=> !pin_out && event_pulse;
  endproperty
  a_force_low: assert property (p_force_low) else $error("force low missed");

  property p_soft;
    (mode == `CCU_M_CMP_SOFT) && !entered |=> pin_out == $past(pin_out);
  endproperty
  a_soft: assert property (p_soft) else $error("pin moved in flag-only mode");

  property p_trig;
    s_match(`CCU_M_CMP_TRIG) |=> trig_pulse ##1 !trig_pulse;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not one cycle");

  property p_capture;
    cap_evt |=> (value == $past(tb_count)) && event_pulse;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_off;
    (mode == `CCU_M_OFF) |=> !pin_out && (ps_ff == 4'h0) && !trig_pulse;
  endproperty
  a_off: assert property (p_off) else $error("disabled unit not reset");

  property p_ps4;
    (mode == `CCU_M_CAP_4) && !entered && rise && (ps_ff == `CCU_CAP4_LAST) |=>
      (ps_ff == 4'h0) && event_pulse;
  endproperty
  a_ps4: assert property (p_ps4) else $error("fourth edge capture missed");
endmodule // ccu_unit

module ccu_top #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tbb_ext_tick,
  input wire logic tbc_match,
  input wire logic unit1_pin_in,
  output logic unit1_pin_out,
  output logic unit1_pin_oe_n,
  input wire logic unit2_pin_in,
  output logic unit2_pin_out,
  output logic unit2_pin_oe_n,
  output logic tbb_ovf_req,
  output logic adc_start,
  output logic [9:0] pwm_duty1,
  output logic [9:0] pwm_duty2
);
  import ccu_pkg::*;

  logic acc;
  logic wr;
  logic w_tbb_lo, w_tbb_hi, w_tbb_ctrl, w_tba_ctrl, w_f2, w_e2, w_p2, w_f1, w_gic;
  logic w_uc1, w_u1_lo, w_u1_hi, w_uc2, w_u2_lo, w_u2_hi;
  logic [31:0] rd_data;
  logic rd_hit;
  logic u1_sel_b, u2_sel_b;
  logic clr_b, clr_a;
  logic [2:0] ps_limit;
  logic tbb_adv, tbb_tick, ovf_set;
  ccu_count_t u1_tb, u2_tb, u1_value, u2_value;
  logic u1_evt, u2_evt, u1_trig, u2_trig;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  ccu_count_t tbb_cnt_ff, nxt_tbb_cnt;
  logic [2:0] tbb_ps_ff, nxt_tbb_ps;
  logic [7:0] tbb_ctrl_ff, nxt_tbb_ctrl;
  ccu_count_t tba_cnt_ff, nxt_tba_cnt;
  logic [7:0] tba_ctrl_ff, nxt_tba_ctrl;
  logic [4:0] f2_ff, nxt_f2;
  logic [4:0] e2_ff, nxt_e2;
  logic [4:0] p2_ff, nxt_p2;
  logic [7:0] f1_ff, nxt_f1;
  logic [7:0] gic_ff, nxt_gic;
  logic [5:0] uc1_ff, nxt_uc1;
  logic [5:0] uc2_ff, nxt_uc2;
  logic req_ff, nxt_req;
  logic adc_ff, nxt_adc;
  logic [9:0] duty1_ff, nxt_duty1;
  logic [9:0] duty2_ff, nxt_duty2;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tbb_ovf_req = req_ff;
  assign adc_start = adc_ff;
  assign pwm_duty1 = duty1_ff;
  assign pwm_duty2 = duty2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: decode in setup, answer in the first access cycle
  always_comb begin
    acc = psel && penable && pready_ff;
    wr = acc && pwrite;
    w_tbb_lo = wr && (paddr == `CCU_OFF_TBB_LO);
    w_tbb_hi = wr && (paddr == `CCU_OFF_TBB_HI);
    w_tbb_ctrl = wr && (paddr == `CCU_OFF_TBB_CTRL);
    w_tba_ctrl = wr && (paddr == `CCU_OFF_TBA_CTRL);
    w_f2 = wr && (paddr == `CCU_OFF_FLAGS2);
    w_e2 = wr && (paddr == `CCU_OFF_ENABLES2);
    w_p2 = wr && (paddr == `CCU_OFF_PRIO2);
    w_uc1 = wr && (paddr == `CCU_OFF_U1_CTRL);
    w_u1_lo = wr && (paddr == `CCU_OFF_U1_LO);
    w_u1_hi = wr && (paddr == `CCU_OFF_U1_HI);
    w_uc2 = wr && (paddr == `CCU_OFF_U2_CTRL);
    w_u2_lo = wr && (paddr == `CCU_OFF_U2_LO);
    w_u2_hi = wr && (paddr == `CCU_OFF_U2_HI);
    w_f1 = wr && (paddr == `CCU_OFF_FLAGS1);
    w_gic = wr && (paddr == `CCU_OFF_GIC);
    rd_hit = 1'b1;
    case (paddr)
      `CCU_OFF_TBB_LO: rd_data = 32'(tbb_cnt_ff[7:0]);
      `CCU_OFF_TBB_HI: rd_data = 32'(tbb_cnt_ff[15:8]);
      `CCU_OFF_TBB_CTRL: rd_data = 32'(tbb_ctrl_ff);
      `CCU_OFF_TBA_CTRL: rd_data = 32'(tba_ctrl_ff);
      `CCU_OFF_FLAGS2: rd_data = 32'(f2_ff);
      `CCU_OFF_ENABLES2: rd_data = 32'(e2_ff);
      `CCU_OFF_PRIO2: rd_data = 32'(p2_ff);
      `CCU_OFF_U1_CTRL: rd_data = 32'(uc1_ff);
      `CCU_OFF_U1_LO: rd_data = 32'(u1_value[7:0]);
      `CCU_OFF_U1_HI: rd_data = 32'(u1_value[15:8]);
      `CCU_OFF_U2_CTRL: rd_data = 32'(uc2_ff);
      `CCU_OFF_U2_LO: rd_data = 32'(u2_value[7:0]);
      `CCU_OFF_U2_HI: rd_data = 32'(u2_value[15:8]);
      `CCU_OFF_FLAGS1: rd_data = 32'(f1_ff);
      `CCU_OFF_TBA_CNT: rd_data = 32'(tba_cnt_ff);
      `CCU_OFF_GIC: rd_data = 32'(gic_ff);
      default: begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    nxt_pready = psel && !penable;
    nxt_prdata = (psel && !penable && !pwrite) ? rd_data : prdata_ff;
    nxt_pslverr = psel && !penable && !rd_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase selection and trigger targets
  always_comb begin
    // Unit two's trigger targets differ from unit one's: it also starts a conversion
    u1_sel_b = tbb_ctrl_ff[`CCU_TBB_SEL2];
    u2_sel_b = tbb_ctrl_ff[`CCU_TBB_SEL2] || tbb_ctrl_ff[`CCU_TBB_SEL1];
    u1_tb = u1_sel_b ? tbb_cnt_ff : tba_cnt_ff;
    u2_tb = u2_sel_b ? tbb_cnt_ff : tba_cnt_ff;
    clr_b = (u1_trig && u1_sel_b) || (u2_trig && u2_sel_b);
    clr_a = (u1_trig && !u1_sel_b) || (u2_trig && !u2_sel_b);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase B; external tick assumed already synchronous to pclk
  always_comb begin
    ps_limit = 3'((4'h1 << tbb_ctrl_ff[`CCU_TBB_PS_HI:`CCU_TBB_PS_LO]) - 4'h1);
    tbb_adv = tbb_ctrl_ff[`CCU_TB_RUN] &&
              (!tbb_ctrl_ff[`CCU_TBB_EXT] || tbb_ext_tick);
    tbb_tick = tbb_adv && (tbb_ps_ff == ps_limit);
    nxt_tbb_ps = tbb_ps_ff;
    if (w_tbb_lo || w_tbb_hi || w_tbb_ctrl) begin
      nxt_tbb_ps = 3'h0;
    end else if (tbb_adv) begin
      nxt_tbb_ps = tbb_tick ? 3'h0 : tbb_ps_ff + 3'h1;
    end
    nxt_tbb_cnt = tbb_cnt_ff;
    ovf_set = 1'b0;
    if (w_tbb_lo || w_tbb_hi) begin
      if (w_tbb_lo) begin
        nxt_tbb_cnt[7:0] = pwdata[7:0];
      end
      if (w_tbb_hi) begin
        nxt_tbb_cnt[15:8] = pwdata[7:0];
      end
    end else if (clr_b) begin
      nxt_tbb_cnt = `CCU_TB_ZERO;
    end else if (tbb_tick) begin
      nxt_tbb_cnt = tbb_cnt_ff + 16'h0001;
      ovf_set = (tbb_cnt_ff == `CCU_TB_MAX);
    end
    nxt_tbb_ctrl = w_tbb_ctrl ? pwdata[7:0] : tbb_ctrl_ff;
    nxt_tba_ctrl = w_tba_ctrl ? pwdata[7:0] : tba_ctrl_ff;
    nxt_tba_cnt = tba_cnt_ff;
    if (clr_a) begin
      nxt_tba_cnt = `CCU_TB_ZERO;
    end else if (tba_ctrl_ff[`CCU_TB_RUN]) begin
      nxt_tba_cnt = tba_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over a same-cycle software clear
  always_comb begin
    nxt_f2 = w_f2 ? pwdata[4:0] : f2_ff;
    nxt_f2[`CCU_F2_OVF] = nxt_f2[`CCU_F2_OVF] || ovf_set;
    nxt_f2[`CCU_F2_UNIT2] = nxt_f2[`CCU_F2_UNIT2] || u2_evt;
    nxt_f1 = w_f1 ? pwdata[7:0] : f1_ff;
    nxt_f1[`CCU_F1_UNIT1] = nxt_f1[`CCU_F1_UNIT1] || u1_evt;
    nxt_e2 = w_e2 ? pwdata[4:0] : e2_ff;
    nxt_p2 = w_p2 ? pwdata[4:0] : p2_ff;
    nxt_gic = w_gic ? pwdata[7:0] : gic_ff;
    nxt_uc1 = w_uc1 ? pwdata[5:0] : uc1_ff;
    nxt_uc2 = w_uc2 ? pwdata[5:0] : uc2_ff;
    nxt_req = f2_ff[`CCU_F2_OVF] && e2_ff[`CCU_F2_OVF];
    nxt_adc = u2_trig;
    nxt_duty1 = duty1_ff;
    nxt_duty2 = duty2_ff;
    // One shared update instant keeps both duty cycles in step
    if (tbc_match) begin
      if (uc1_ff[`CCU_UC_MODE_HI -: 2] == `CCU_PWM_PFX) begin
        nxt_duty1 = {u1_value[7:0], uc1_ff[`CCU_UC_DC_HI:`CCU_UC_DC_LO]};
      end
      if (uc2_ff[`CCU_UC_MODE_HI -: 2] == `CCU_PWM_PFX) begin
        nxt_duty2 = {u2_value[7:0], uc2_ff[`CCU_UC_DC_HI:`CCU_UC_DC_LO]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      tbb_cnt_ff <= `CCU_TB_ZERO;
      tbb_ps_ff <= 3'h0;
      tbb_ctrl_ff <= `CCU_CTRL_RST;
      tba_cnt_ff <= `CCU_TB_ZERO;
      tba_ctrl_ff <= `CCU_CTRL_RST;
      f2_ff <= 5'h00;
      e2_ff <= 5'h00;
      p2_ff <= `CCU_PRIO2_RST;
      f1_ff <= `CCU_CTRL_RST;
      gic_ff <= `CCU_CTRL_RST;
      uc1_ff <= 6'h00;
      uc2_ff <= 6'h00;
      req_ff <= 1'b0;
      adc_ff <= 1'b0;
      duty1_ff <= 10'h000;
      duty2_ff <= 10'h000;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      tbb_cnt_ff <= nxt_tbb_cnt;
      tbb_ps_ff <= nxt_tbb_ps;
      tbb_ctrl_ff <= nxt_tbb_ctrl;
      tba_cnt_ff <= nxt_tba_cnt;
      tba_ctrl_ff <= nxt_tba_ctrl;
      f2_ff <= nxt_f2;
      e2_ff <= nxt_e2;
      p2_ff <= nxt_p2;
      f1_ff <= nxt_f1;
      gic_ff <= nxt_gic;
      uc1_ff <= nxt_uc1;
      uc2_ff <= nxt_uc2;
      req_ff <= nxt_req;
      adc_ff <= nxt_adc;
      duty1_ff <= nxt_duty1;
      duty2_ff <= nxt_duty2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Units
  ccu_unit u_unit1 (
    .pclk(pclk),
    .presetn(presetn),
    .mode(uc1_ff[3:0]),
    .tb_count(u1_tb),
    .pin_in(unit1_pin_in),
    .wr_lo(w_u1_lo),
    .wr_hi(w_u1_hi),
    .wdata(pwdata[7:0]),
    .value(u1_value),
    .pin_out(unit1_pin_out),
    .pin_oe_n(unit1_pin_oe_n),
    .event_pulse(u1_evt),
    .trig_pulse(u1_trig)
  );

  ccu_unit u_unit2 (
    .pclk(pclk),
    .presetn(presetn),
    .mode(uc2_ff[3:0]),
    .tb_count(u2_tb),
    .pin_in(unit2_pin_in),
    .wr_lo(w_u2_lo),
    .wr_hi(w_u2_hi),
    .wdata(pwdata[7:0]),
    .value(u2_value),
    .pin_out(unit2_pin_out),
    .pin_oe_n(unit2_pin_oe_n),
    .event_pulse(u2_evt),
    .trig_pulse(u2_trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wrap;
    tbb_tick && !w_tbb_lo && !w_tbb_hi && !clr_b && (tbb_cnt_ff == `CCU_TB_MAX) |=>
      (tbb_cnt_ff == `CCU_TB_ZERO) && f2_ff[`CCU_F2_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap lost or flag not set");

  property p_req;
    f2_ff[`CCU_F2_OVF] && !e2_ff[`CCU_F2_OVF] |=> !tbb_ovf_req;
  endproperty
  a_req: assert property (p_req) else $error("request passed while disabled");

  property p_trig_clr;
    clr_b && !w_tbb_lo && !w_tbb_hi && !w_f2 && !f2_ff[`CCU_F2_OVF] |=>
      (tbb_cnt_ff == `CCU_TB_ZERO) && !f2_ff[`CCU_F2_OVF];
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("trigger clear wrong");

  property p_write_wins;
    clr_b && w_tbb_lo |=> tbb_cnt_ff[7:0] == $past(pwdata[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

  property p_flag_hold;
    f1_ff[`CCU_F1_UNIT1] && !w_f1 |=> f1_ff[`CCU_F1_UNIT1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");
endmodule // ccu_top

// ==== bench/ccu_pin_src.sv ====
// Pin partner: outside source level merged with the unit's own pin driver
`timescale 1ns/10ps

module ccu_pin_src (
  input wire logic ext_lvl,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in
);
  // A driven pin reads back its own level, so port writes can still capture
  assign pin_in = pin_oe_n ? ext_lvl : pin_out;
endmodule // ccu_pin_src

// ==== bench/tb_capture_compare_unit_with_timebase.sv ====
// Register-level bench for the capture/compare unit pair and timebase B
`timescale 1ns/10ps
`include "ccu_cfg.svh"

module tb_capture_compare_unit_with_timebase;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic tbc_match, ext1, ext2, u1_in, u1_out, u1_oe_n, u2_in, u2_out, u2_oe_n, ovf_req;
  logic [9:0] duty1, duty2;
  logic adc;
  logic [31:0] n_adc;
  logic [3:0] cm [5] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
  logic [4:0] pin_exp = 5'h1d;
  logic [4:0] oe_exp = 5'h18;
  int cnt [4] = '{1, 1, 4, 16};
  int n_fail, check_count, cyc;

  ccu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tbb_ext_tick(1'b0), .tbc_match(tbc_match),
    .unit1_pin_in(u1_in), .unit1_pin_out(u1_out), .unit1_pin_oe_n(u1_oe_n),
    .unit2_pin_in(u2_in), .unit2_pin_out(u2_out), .unit2_pin_oe_n(u2_oe_n),
    .tbb_ovf_req(ovf_req), .adc_start(adc), .pwm_duty1(duty1), .pwm_duty2(duty2));
  ccu_pin_src u_pin1 (.ext_lvl(ext1), .pin_out(u1_out), .pin_oe_n(u1_oe_n), .pin_in(u1_in));
  ccu_pin_src u_pin2 (.ext_lvl(ext2), .pin_out(u2_out), .pin_oe_n(u2_oe_n), .pin_in(u2_in));

  always #4 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the roughly 700 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      finish_test;
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so back-to-back calls never drive psel twice in one step
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, r, e);
  endtask

  task pulse;
    ext1 <= 1'b1;
    repeat (3) @(posedge pclk);
    ext1 <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, tbc_match, ext1, ext2} = '0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CCU_OFF_PRIO2, 32'h0000001f, "prio2");
    rd(`CCU_OFF_FLAGS2, 32'h00000000, "flags2");
    rd(`CCU_OFF_TBB_CTRL, 32'h00000000, "tbb_ctrl");
    rd(8'h40, 32'h00000000, "unmapped");
    chk("slverr", {31'h0, perr}, 32'h1);
    // Overflow with the request masked, then unmasked
    wr(`CCU_OFF_TBB_HI, 8'hff);
    wr(`CCU_OFF_TBB_LO, 8'hfd);
    wr(`CCU_OFF_TBB_CTRL, 8'h01);
    repeat (10) @(posedge pclk);
    rd(`CCU_OFF_FLAGS2, 32'h00000002, "ovf_flag");
    rd(`CCU_OFF_TBB_HI, 32'h00000000, "wrap_hi");
    chk("ovf_masked", {31'h0, ovf_req}, 32'h0);
    wr(`CCU_OFF_ENABLES2, 8'h02);
    repeat (3) @(posedge pclk);
    chk("ovf_req", {31'h0, ovf_req}, 32'h1);
    wr(`CCU_OFF_ENABLES2, 8'h00);
    // Capture of a frozen timebase B, every edge mode
    for (int k = 0; k < 4; k++) begin
      wr(`CCU_OFF_U1_CTRL, 8'h00);
      wr(`CCU_OFF_TBB_CTRL, 8'h40);
      wr(`CCU_OFF_TBB_LO, 8'h3c);
      wr(`CCU_OFF_TBB_HI, 8'(k + 1));
      wr(`CCU_OFF_FLAGS1, 8'h00);
      wr(`CCU_OFF_U1_CTRL, 8'(4 + k));
      repeat (cnt[k] - 1) pulse;
      rd(`CCU_OFF_FLAGS1, 32'h00000000, "cap_early");
      pulse;
      rd(`CCU_OFF_FLAGS1, 32'h00000004, "cap_flag");
      rd(`CCU_OFF_U1_LO, 32'h0000003c, "cap_lo");
      rd(`CCU_OFF_U1_HI, 32'(k + 1), "cap_hi");
    end
    // Compare against a running timebase B, value 0010h
    wr(`CCU_OFF_U1_LO, 8'h10);
    wr(`CCU_OFF_U1_HI, 8'h00);
    rd(`CCU_OFF_U1_LO, 32'h00000010, "val_lo");
    wr(`CCU_OFF_FLAGS2, 8'h00);
    for (int k = 0; k < 5; k++) begin
      wr(`CCU_OFF_TBB_CTRL, 8'h40);
      wr(`CCU_OFF_TBB_LO, 8'h00);
      wr(`CCU_OFF_TBB_HI, 8'h00);
      wr(`CCU_OFF_U1_CTRL, {4'h0, cm[k]});
      wr(`CCU_OFF_FLAGS1, 8'h00);
      if (k < 2)
        chk("pin_init", {31'h0, u1_out}, {31'h0, k[0]});
      wr(`CCU_OFF_TBB_CTRL, 8'h41);
      repeat (40) @(posedge pclk);
      rd(`CCU_OFF_FLAGS1, 32'h00000004, "cmp_flag");
      chk("cmp_pin", {31'h0, u1_out}, {31'h0, pin_exp[k]});
      chk("cmp_oe_n", {31'h0, u1_oe_n}, {31'h0, oe_exp[k]});
    end
    // Trigger kept clearing the count without touching the overflow flag
    wr(`CCU_OFF_TBB_CTRL, 8'h40);
    rd(`CCU_OFF_TBB_HI, 32'h00000000, "trig_hi");
    apb(1'b0, `CCU_OFF_TBB_LO, 8'h00);
    chk("trig_lo", {31'h0, r <= 32'h11}, 32'h1);
    rd(`CCU_OFF_FLAGS2, 32'h00000000, "trig_ovf");
    wr(`CCU_OFF_U1_CTRL, 8'h00);
    // Latch clears one edge after the mode register changes
    @(posedge pclk);
    chk("off_pin", {30'h0, u1_oe_n, u1_out}, 32'h2);
    wr(`CCU_OFF_U1_CTRL, 8'h03);
    repeat (20) @(posedge pclk);
    chk("rsvd_pin", {30'h0, u1_oe_n, u1_out}, 32'h2);
    // Unit two trigger starts exactly one conversion per match
    wr(`CCU_OFF_TBB_LO, 8'h00);
    wr(`CCU_OFF_U2_LO, 8'h10);
    wr(`CCU_OFF_U2_CTRL, 8'h0b);
    wr(`CCU_OFF_TBB_CTRL, 8'h41);
    n_adc = 32'h0;
    repeat (30) @(posedge pclk) n_adc += adc;
    chk("adc_start", n_adc, 32'h1);
    chk("u2_pin", {30'h0, u2_oe_n, u2_out}, 32'h2);
    // PWM duty takes effect only at the timebase C match
    wr(`CCU_OFF_U2_LO, 8'ha5);
    wr(`CCU_OFF_U2_CTRL, 8'h3c);
    wr(`CCU_OFF_U1_CTRL, 8'h1c);
    chk("duty_hold", {12'h0, duty1, duty2}, 32'h0);
    tbc_match <= 1'b1;
    @(posedge pclk);
    tbc_match <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("duty", {22'h0, duty2}, 32'h00000297);
    chk("duty1", {22'h0, duty1}, 32'h00000041);
    finish_test;
  end
endmodule // tb_capture_compare_unit_with_timebase
